// File: inc/pgt_pkg.sv
`default_nettype none
package pgt_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFF_OUT3_MASK_A = 8'hAA;
	localparam logic [7:0] OFF_OUT3_MASK_B = 8'hAB;
	localparam logic [7:0] OFF_CTL_MASKS   = 8'hAC;
	localparam logic [7:0] OFF_AUX1_CTL    = 8'hAE;
	localparam logic [7:0] OFF_STATUS_A    = 8'hB0;
	localparam logic [7:0] OFF_STATUS_B    = 8'hB1;
	localparam logic [7:0] OFF_IRQ_STAT    = 8'hB8;
	localparam logic [7:0] OFF_IRQ_MASK    = 8'hB9;

	// Reset values
	localparam logic [7:0] RST_OUT3_MASK = 8'h00;
	localparam logic [7:0] RST_CTL_MASKS = 8'hFF;
	localparam logic [7:0] RST_AUX1_CTL  = 8'h7D;
	localparam logic [7:0] RST_IRQ_MASK  = 8'h00;
	localparam logic [7:0] RD_ZERO       = 8'h00;

	// Control input positions in the sampled pin vector
	localparam int CTL_1 = 0;
	localparam int CTL_2 = 1;
	localparam int CTL_3 = 2;
	localparam int CTL_4 = 3;
	localparam int CTL_5 = 4;
	localparam int CTL_6 = 5;

	// Second status word layout
	localparam int G2_TERM = 3;
	localparam int G2_LOAD_SWITCH_B_TWO = 2;
	localparam int G2_LOAD_SWITCH_B_ONE = 1;
	localparam int G2_AUX3 = 0;

	// Power-good output positions
	localparam int PG_O1 = 0;
	localparam int PG_O2 = 1;
	localparam int PG_O3 = 2;
	localparam int PG_O4 = 3;

	// Control pin tree mask positions
	localparam int MISC_O3_CONTROL_INPUT_SIX = 7;
	localparam int MISC_O3_CONTROL_INPUT_THREE = 6;
	localparam int MISC_O2_CONTROL_INPUT_SIX = 5;
	localparam int MISC_O2_CONTROL_INPUT_THREE = 4;
	localparam int MISC_O4_CONTROL_INPUT_SIX = 3;
	localparam int MISC_O4_CONTROL_INPUT_THREE = 2;
	localparam int MISC_O1_CONTROL_INPUT_SIX = 1;
	localparam int MISC_O1_CONTROL_INPUT_THREE = 0;

	// Second output-3 mask positions
	localparam int M2_CONTROL_INPUT_FIVE = 7;
	localparam int M2_CONTROL_INPUT_FOUR = 6;
	localparam int M2_CONTROL_INPUT_TWO = 5;
	localparam int M2_CONTROL_INPUT_ONE = 4;
	localparam int M2_TERM = 3;

	// Interrupt status layout: bits 3..0 output lost good, bit 4 forced shutdown
	localparam int IRQ_W    = 5;
	localparam int IRQ_SHDN = 4;

	// Timing
	localparam int CLK_HZ     = 20_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int SHDN_MS_0  = 1;
	localparam int SHDN_MS_1  = 5;
	localparam int SHDN_MS_2  = 10;
	localparam int SHDN_MS_3  = 100;
	localparam int SHDN_CYC_0 = SHDN_MS_0 * CYC_PER_MS;
	localparam int SHDN_CYC_1 = SHDN_MS_1 * CYC_PER_MS;
	localparam int SHDN_CYC_2 = SHDN_MS_2 * CYC_PER_MS;
	localparam int SHDN_CYC_3 = SHDN_MS_3 * CYC_PER_MS;

	localparam int SYNC_W = 21;

	typedef struct packed {
		logic [1:0] discharge;
		logic       sdwn_cfg;
		logic [3:0] vcode;
		logic       enable;
	} pgt_aux_ctl_t;

	typedef struct packed {
		logic       esd;
		logic [5:0] good2;
		logic [7:0] good1;
		logic [5:0] ctl;
	} pgt_inputs_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} pgt_bus_t;

	typedef enum logic [1:0] {
		SD_RUN  = 2'h1,
		SD_HOLD = 2'h2
	} pgt_sd_state_t;

	// A masked member counts as good
	function automatic logic pgt_pair_good(logic c6, logic c3, logic m6, logic m3);
		return (c6 | m6) & (c3 | m3);
	endfunction : pgt_pair_good

endpackage : pgt_pkg
`default_nettype wire

// File: rtl/pgt_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pgt_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic [W-1:0] d_in,
	output var  logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_r <= '0;
			q_out  <= '0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule : pgt_sync
`default_nettype wire

// File: rtl/pgt_regs.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// [RL1] Second output-3 mask bits 7..4 drop control inputs 5,4,2,1 from tree.
// [RL2] Its bits 3..0 drop termination, switch B2, B1, aux three; reset zero.
// [RL3] Control mask bits 7,6 drop inputs 6,3 from output three; reset one.
// [RL4] Control mask bits 5,4 drop inputs 6,3 from output two; reset one.
// [RL5] Control mask bits 3,2 drop inputs 6,3 from output four; reset one.
// [RL6] Control mask bits 1,0 drop inputs 6,3 from output one; reset one.
// [RL7] Shutdown config zero: emergency shutdown forces aux one off for fixed time.
// [RL8] Shutdown config one: aux one follows enable bit 0 only, reset one.
// [RL9] Aux one voltage code sits in bits 4..1, reset Eh.
// [RL10] First status reads live good of aux two, switch A1, step-down 6..1.
// [RL11] First output-3 mask drops step-down 1..6, switch A1, aux two.
// [RL12] Output is good only while every unmasked tree member is good.
module pgt_regs
	import pgt_pkg::*;
#(
	parameter int         T_SHDN0_CYC = SHDN_CYC_0,
	parameter int         T_SHDN1_CYC = SHDN_CYC_1,
	parameter int         T_SHDN2_CYC = SHDN_CYC_2,
	parameter int         T_SHDN3_CYC = SHDN_CYC_3,
	parameter logic [1:0] SHDN_SEL    = 2'h0
) (
	input  wire logic              REF_CLK_IN,
	input  wire logic              NRST_IN,
	input  wire logic [ADDR_W-1:0] ADDR_IN,
	input  wire logic [DATA_W-1:0] WDATA_IN,
	input  wire logic              WR_IN,
	input  wire logic              RD_IN,
	output var  logic [DATA_W-1:0] RDATA_OUT,
	input  wire logic [5:0]        CTL_PINS_IN,
	input  wire logic [7:0]        RAIL_GOOD_A_IN,
	input  wire logic [5:0]        RAIL_GOOD_B_IN,
	input  wire logic              EMERG_SHDN_IN,
	output var  logic [3:0]        PG_OUTPUTS_OUT,
	output var  logic              AUX_ONE_ENABLE_OUT,
	output logic      [3:0]        AUX_ONE_VOLTAGE_CODE_OUT,
	output logic      [1:0]        AUX_ONE_DISCHARGE_SELECT_OUT,
	output var  logic              IRQ_OUT
);
	// Factory-programmed forced-off time, never below one cycle
	localparam int HOLD_RAW = (SHDN_SEL == 2'h0) ? T_SHDN0_CYC :
	                          (SHDN_SEL == 2'h1) ? T_SHDN1_CYC :
	                          (SHDN_SEL == 2'h2) ? T_SHDN2_CYC : T_SHDN3_CYC;
	localparam int HOLD_CYC = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
	localparam int CNT_W    = $clog2(HOLD_CYC + 1);
	localparam logic [CNT_W-1:0] HOLD_LEN = CNT_W'(HOLD_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	pgt_bus_t      bus;
	pgt_inputs_t   pin_raw;
	pgt_inputs_t   pin_s;

	logic [7:0]    mask1_r;
	logic [7:0]    mask1_nxt;
	logic [7:0]    mask2_r;
	logic [7:0]    mask2_nxt;
	logic [7:0]    misc_r;
	logic [7:0]    misc_nxt;
	pgt_aux_ctl_t  aux_r;
	pgt_aux_ctl_t  aux_nxt;
	logic [7:0]    irq_mask_r;
	logic [7:0]    irq_mask_nxt;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_stat_nxt;
	logic [IRQ_W-1:0] irq_ev;
	logic          irq_nxt;
	logic [DATA_W-1:0] rdata_nxt;

	logic [15:0]   o3_members;
	logic [15:0]   o3_mask;
	logic [3:0]    pg_nxt;
	logic          aux_en_nxt;

	pgt_sd_state_t sd_r;
	pgt_sd_state_t sd_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic          esd_d_r;
	logic          esd_rise;
	logic          shdn_start;

	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!NRST_IN);

	assign bus     = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};
	assign pin_raw = '{esd: EMERG_SHDN_IN, good2: RAIL_GOOD_B_IN,
	                   good1: RAIL_GOOD_A_IN, ctl: CTL_PINS_IN};

	// Every pin and rail flag is asynchronous to the register clock
	pgt_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk_in  (REF_CLK_IN),
		.nrst_in (NRST_IN),
		.d_in    (pin_raw),
		.q_out   (pin_s)
	);

	// Register file writes
	always_comb begin
		mask1_nxt    = mask1_r;
		mask2_nxt    = mask2_r;
		misc_nxt     = misc_r;
		aux_nxt      = aux_r;
		irq_mask_nxt = irq_mask_r;
		if (bus.wr) begin
			case (bus.addr)
				OFF_OUT3_MASK_A: mask1_nxt = bus.wdata; // see [RL11]
				OFF_OUT3_MASK_B: mask2_nxt = bus.wdata; // see [RL1] see [RL2]
				OFF_CTL_MASKS:   misc_nxt  = bus.wdata; // see [RL3]
				OFF_AUX1_CTL:    aux_nxt   = pgt_aux_ctl_t'(bus.wdata); // see [RL9]
				OFF_IRQ_MASK:    irq_mask_nxt = bus.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			mask1_r    <= RST_OUT3_MASK;
			mask2_r    <= RST_OUT3_MASK; // see [RL2]
			misc_r     <= RST_CTL_MASKS; // see [RL3] see [RL4] see [RL5] see [RL6]
			aux_r      <= pgt_aux_ctl_t'(RST_AUX1_CTL); // see [RL8] see [RL9]
			irq_mask_r <= RST_IRQ_MASK;
		end else begin
			mask1_r    <= mask1_nxt;
			mask2_r    <= mask2_nxt;
			misc_r     <= misc_nxt;
			aux_r      <= aux_nxt;
			irq_mask_r <= irq_mask_nxt;
		end
	end

	// Power-good trees; outputs one, two and four carry only their control pin members
	assign o3_members = {pin_s.ctl[CTL_5], pin_s.ctl[CTL_4], pin_s.ctl[CTL_2],
	                     pin_s.ctl[CTL_1], pin_s.good2[G2_TERM], pin_s.good2[G2_LOAD_SWITCH_B_TWO],
	                     pin_s.good2[G2_LOAD_SWITCH_B_ONE], pin_s.good2[G2_AUX3], pin_s.good1};
	assign o3_mask    = {mask2_r, mask1_r};

	always_comb begin
		pg_nxt[PG_O1] = pgt_pair_good(pin_s.ctl[CTL_6], pin_s.ctl[CTL_3],
		                              misc_r[MISC_O1_CONTROL_INPUT_SIX], misc_r[MISC_O1_CONTROL_INPUT_THREE]); // see [RL6]
		pg_nxt[PG_O2] = pgt_pair_good(pin_s.ctl[CTL_6], pin_s.ctl[CTL_3],
		                              misc_r[MISC_O2_CONTROL_INPUT_SIX], misc_r[MISC_O2_CONTROL_INPUT_THREE]); // see [RL4]
		pg_nxt[PG_O4] = pgt_pair_good(pin_s.ctl[CTL_6], pin_s.ctl[CTL_3],
		                              misc_r[MISC_O4_CONTROL_INPUT_SIX], misc_r[MISC_O4_CONTROL_INPUT_THREE]); // see [RL5]
		pg_nxt[PG_O3] = (&(o3_members | o3_mask)) // see [RL1] see [RL2] see [RL11] see [RL12]
		                & pgt_pair_good(pin_s.ctl[CTL_6], pin_s.ctl[CTL_3],
		                                misc_r[MISC_O3_CONTROL_INPUT_SIX], misc_r[MISC_O3_CONTROL_INPUT_THREE]); // see [RL3]
	end

	// Emergency shutdown hold; a new request during the hold is ignored
	assign esd_rise = pin_s.esd & ~esd_d_r;

	always_comb begin
		sd_nxt     = sd_r;
		cnt_nxt    = cnt_r;
		shdn_start = 1'b0;
		unique case (sd_r)
			SD_RUN: begin
				if (esd_rise && !aux_r.sdwn_cfg) begin // see [RL7]
					sd_nxt     = SD_HOLD;
					cnt_nxt    = HOLD_LEN;
					shdn_start = 1'b1;
				end
			end
			SD_HOLD: begin
				if (cnt_r == CNT_ONE) begin
					sd_nxt = SD_RUN;
				end else begin
					cnt_nxt = cnt_r - CNT_ONE;
				end
			end
			default: sd_nxt = SD_RUN;
		endcase
		// Setting the config bit mid-hold returns control to the enable bit at once
		aux_en_nxt = aux_r.enable & (aux_r.sdwn_cfg | (sd_nxt != SD_HOLD)); // see [RL7] see [RL8]
	end

	always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			sd_r               <= SD_RUN;
			cnt_r              <= '0;
			esd_d_r            <= 1'b0;
			PG_OUTPUTS_OUT     <= '0;
			AUX_ONE_ENABLE_OUT <= 1'b0;
		end else begin
			sd_r               <= sd_nxt;
			cnt_r              <= cnt_nxt;
			esd_d_r            <= pin_s.esd;
			PG_OUTPUTS_OUT     <= pg_nxt;
			AUX_ONE_ENABLE_OUT <= aux_en_nxt;
		end
	end

	assign AUX_ONE_VOLTAGE_CODE_OUT     = aux_r.vcode; // see [RL9]
	assign AUX_ONE_DISCHARGE_SELECT_OUT = aux_r.discharge;

	// Interrupts and read port; a new event beats the read-clear of the same cycle
	assign irq_ev = {shdn_start, PG_OUTPUTS_OUT & ~pg_nxt};

	always_comb begin
		irq_stat_nxt = irq_stat_r;
		if (bus.rd && (bus.addr == OFF_IRQ_STAT)) begin
			irq_stat_nxt = '0;
		end
		irq_stat_nxt = irq_stat_nxt | irq_ev;
		irq_nxt      = |(irq_stat_nxt & ~irq_mask_nxt[IRQ_W-1:0]);
		rdata_nxt    = RD_ZERO;
		if (bus.rd) begin
			case (bus.addr)
				OFF_OUT3_MASK_A: rdata_nxt = mask1_r;
				OFF_OUT3_MASK_B: rdata_nxt = mask2_r;
				OFF_CTL_MASKS:   rdata_nxt = misc_r;
				OFF_AUX1_CTL:    rdata_nxt = aux_r;
				OFF_STATUS_A:    rdata_nxt = pin_s.good1; // see [RL10]
				OFF_STATUS_B:    rdata_nxt = DATA_W'(pin_s.good2);
				OFF_IRQ_STAT:    rdata_nxt = DATA_W'(irq_stat_r);
				OFF_IRQ_MASK:    rdata_nxt = irq_mask_r;
				default:         rdata_nxt = RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			irq_stat_r <= '0;
			IRQ_OUT    <= 1'b0;
			RDATA_OUT  <= RD_ZERO;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			IRQ_OUT    <= irq_nxt;
			RDATA_OUT  <= rdata_nxt;
		end
	end

	out3_ctl_a : assert property ( // see [RL1]
		!pin_s.ctl[CTL_5] && !mask2_r[M2_CONTROL_INPUT_FIVE] |=> !PG_OUTPUTS_OUT[PG_O3])
		else $error("output three good with unmasked control five low");

	out3_rail_a : assert property ( // see [RL2]
		bus.wr && bus.addr == OFF_OUT3_MASK_B ##1 !pin_s.good2[G2_TERM]
		&& !mask2_r[M2_TERM] |=> !PG_OUTPUTS_OUT[PG_O3])
		else $error("output three ignores unmasked termination regulator");

	out3_pins_a : assert property ( // see [RL3]
		!pin_s.ctl[CTL_6] && !misc_r[MISC_O3_CONTROL_INPUT_SIX] |=> !PG_OUTPUTS_OUT[PG_O3])
		else $error("output three ignores unmasked control six");

	out2_pins_a : assert property ( // see [RL4]
		!pin_s.ctl[CTL_3] && !misc_r[MISC_O2_CONTROL_INPUT_THREE] |=> !PG_OUTPUTS_OUT[PG_O2])
		else $error("output two ignores unmasked control three");

	out4_pins_a : assert property ( // see [RL5]
		!pin_s.ctl[CTL_6] && !misc_r[MISC_O4_CONTROL_INPUT_SIX] |=> !PG_OUTPUTS_OUT[PG_O4])
		else $error("output four ignores unmasked control six");

	out1_masked_a : assert property ( // see [RL6] see [RL12]
		misc_r[MISC_O1_CONTROL_INPUT_SIX] && misc_r[MISC_O1_CONTROL_INPUT_THREE] |=> PG_OUTPUTS_OUT[PG_O1])
		else $error("fully masked output one not good");

	shdn_force_a : assert property ( // see [RL7]
		sd_r == SD_RUN && esd_rise && !aux_r.sdwn_cfg |=> !AUX_ONE_ENABLE_OUT [*2])
		else $error("aux one not forced off by emergency shutdown");

	shdn_len_a : assert property ( // see [RL7]
		$rose(sd_r == SD_HOLD) |-> cnt_r == HOLD_LEN)
		else $error("forced-off time loaded with wrong length");

	en_follow_a : assert property ( // see [RL8]
		aux_r.sdwn_cfg |=> AUX_ONE_ENABLE_OUT == $past(aux_r.enable))
		else $error("aux one enable not following its bit");

	vcode_wr_a : assert property ( // see [RL9]
		bus.wr && bus.addr == OFF_AUX1_CTL |=> AUX_ONE_VOLTAGE_CODE_OUT == $past(bus.wdata[4:1]))
		else $error("voltage code not taken from bits 4 to 1");

	stat_rd_a : assert property ( // see [RL10]
		bus.rd && bus.addr == OFF_STATUS_A |=> RDATA_OUT == $past(pin_s.good1))
		else $error("first status read does not show live rail good");

	out3_step_a : assert property ( // see [RL11]
		!pin_s.good1[0] && !mask1_r[0] |=> !PG_OUTPUTS_OUT[PG_O3])
		else $error("output three ignores unmasked step-down one");

	irq_level_a : assert property (
		irq_stat_r[IRQ_SHDN] && !irq_mask_r[IRQ_SHDN] |-> IRQ_OUT)
		else $error("interrupt low with unmasked status set");

	hold_cv : cover property (sd_r == SD_RUN ##1 sd_r == SD_HOLD);
	out3_up_cv : cover property ($rose(PG_OUTPUTS_OUT[PG_O3]));
	irq_cv : cover property ($rose(IRQ_OUT));
	irq_clr_cv : cover property (IRQ_OUT && bus.rd && bus.addr == OFF_IRQ_STAT ##1 !IRQ_OUT);

endmodule : pgt_regs
`default_nettype wire

// File: tb/power_good_tree_mask_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module power_good_tree_mask_regs_tb;
	import pgt_pkg::*;
	// Short hold keeps the forced-off window quick to walk through
	localparam int HOLD = 8;
	logic        clk, nrst, wr, rd, esd, en, irq, rd_pend;
	logic [7:0]  addr, wdata, rdata, rga, m_a, m_b, m_c;
	logic [5:0]  ctl, rgb;
	logic [3:0]  pg, vcode, exp_pg;
	logic [1:0]  dis;
	logic [15:0] expq[$];
	logic [15:0] e;
	logic [7:0]  regs[4];
	logic [7:0]  v[4];
	int          failures, checks, seed, n;

	pgt_regs #(.T_SHDN0_CYC(HOLD), .T_SHDN1_CYC(HOLD), .T_SHDN2_CYC(HOLD),
		.T_SHDN3_CYC(HOLD)) pgt_regs_i (
		.REF_CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CTL_PINS_IN(ctl),
		.RAIL_GOOD_A_IN(rga), .RAIL_GOOD_B_IN(rgb), .EMERG_SHDN_IN(esd),
		.PG_OUTPUTS_OUT(pg), .AUX_ONE_ENABLE_OUT(en), .AUX_ONE_VOLTAGE_CODE_OUT(vcode),
		.AUX_ONE_DISCHARGE_SELECT_OUT(dis), .IRQ_OUT(irq));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic complete_run;
		if (failures == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	task automatic check(input string nm, input logic [7:0] seen, exp, care);
		checks++;
		if (((seen ^ exp) & care) !== 8'h00) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	function automatic logic [7:0] rnd8();
		int r;
		r = $random(seed);
		return r[7:0];
	endfunction : rnd8

	task automatic bus(input logic w, r, input logic [7:0] a, d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask : bus

	task automatic wrr(input logic [7:0] a, d);
		bus(1'b1, 1'b0, a, d);
	endtask : wrr

	// Care mask lets a read clear sticky bits without judging them
	task automatic rdx(input logic [7:0] a, x, c);
		expq.push_back({c, x});
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rdx

	task automatic settle(input int k);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask : settle

	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_pend) begin
			if (expq.size() == 0) begin
				check("read queue", 8'h01, 8'h00, 8'hFF);
			end else begin
				e = expq.pop_front();
				check("read data", rdata, e[7:0], e[15:8]);
			end
		end
		rd_pend <= rd;
	end

	initial begin
		nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00; esd = 1'b0;
		ctl = 6'h3F; rga = 8'hFF; rgb = 6'h3F; rd_pend = 1'b0;
		seed = 32'h0484; failures = 0; checks = 0;
		regs = '{OFF_OUT3_MASK_A, OFF_OUT3_MASK_B, OFF_CTL_MASKS, OFF_AUX1_CTL};
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rdx(OFF_OUT3_MASK_A, 8'h00, 8'hFF);
		rdx(OFF_OUT3_MASK_B, 8'h00, 8'hFF);
		rdx(OFF_CTL_MASKS, 8'hFF, 8'hFF);
		rdx(OFF_AUX1_CTL, 8'h7D, 8'hFF);
		rdx(8'h10, 8'h00, 8'hFF);
		settle(1);
		check("enable", {7'h0, en}, 8'h01, 8'hFF);
		check("voltage code", {4'h0, vcode}, 8'h0E, 8'hFF);
		foreach (regs[i]) begin
			v[i] = rnd8();
			wrr(regs[i], v[i]);
		end
		wrr(OFF_STATUS_A, 8'h00);
		foreach (regs[i]) rdx(regs[i], v[i], 8'hFF);
		rga <= rnd8();
		rgb <= 6'(rnd8());
		settle(4);
		check("voltage code", {4'h0, vcode}, {4'h0, v[3][4:1]}, 8'hFF);
		rdx(OFF_STATUS_A, rga, 8'hFF);
		rdx(OFF_STATUS_B, {2'b00, rgb}, 8'hFF);
		for (n = 0; n < 40; n++) begin
			m_a = rnd8() | rnd8();
			m_b = rnd8() | rnd8();
			m_c = rnd8();
			wrr(OFF_OUT3_MASK_A, m_a);
			wrr(OFF_OUT3_MASK_B, m_b);
			wrr(OFF_CTL_MASKS, m_c);
			ctl <= 6'(rnd8() | rnd8());
			rga <= rnd8() | rnd8() | rnd8();
			rgb <= 6'(rnd8() | rnd8() | rnd8());
			settle(5);
			exp_pg[0] = (ctl[5] | m_c[1]) & (ctl[2] | m_c[0]);
			exp_pg[1] = (ctl[5] | m_c[5]) & (ctl[2] | m_c[4]);
			exp_pg[3] = (ctl[5] | m_c[3]) & (ctl[2] | m_c[2]);
			exp_pg[2] = (ctl[5] | m_c[7]) & (ctl[2] | m_c[6]) & (&(rga | m_a))
				& (&({ctl[4], ctl[3], ctl[1], ctl[0], rgb[3:0]} | m_b));
			check("pg 1 2 4", {4'h0, pg}, {4'h0, exp_pg}, 8'h0B);
			check("pg three", {4'h0, pg}, {4'h0, exp_pg}, 8'h04);
		end
		wrr(OFF_CTL_MASKS, 8'h00);
		ctl <= 6'h3F;
		rga <= 8'hFF;
		rgb <= 6'h3F;
		settle(5);
		rdx(OFF_IRQ_STAT, 8'h00, 8'h00);
		settle(2);
		check("irq idle", {7'h0, irq}, 8'h00, 8'hFF);
		@(posedge clk);
		ctl <= 6'h3B;
		settle(5);
		check("irq raised", {7'h0, irq}, 8'h01, 8'hFF);
		rdx(OFF_IRQ_STAT, 8'h0F, 8'h1F);
		settle(2);
		check("irq cleared", {7'h0, irq}, 8'h00, 8'hFF);
		wrr(OFF_IRQ_MASK, 8'h1F);
		ctl <= 6'h3F;
		settle(5);
		@(posedge clk);
		ctl <= 6'h3B;
		settle(5);
		check("irq masked", {7'h0, irq}, 8'h00, 8'hFF);
		rdx(OFF_IRQ_STAT, 8'h0F, 8'h1F);
		wrr(OFF_IRQ_MASK, 8'h00);
		wrr(OFF_AUX1_CTL, 8'h7D);
		esd <= 1'b1;
		settle(8);
		check("enable kept", {7'h0, en}, 8'h01, 8'hFF);
		@(posedge clk);
		esd <= 1'b0;
		rdx(OFF_IRQ_STAT, 8'h00, 8'h10);
		wrr(OFF_AUX1_CTL, 8'h5D);
		settle(3);
		@(posedge clk);
		esd <= 1'b1;
		n = 0;
		while (en !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		// A missed shutdown is counted and the run goes on to the verdict
		if (n >= 20) begin
			failures++;
		end
		check("irq on shutdown", {7'h0, irq}, 8'h01, 8'hFF);
		n = 0;
		while (en === 1'b0 && n < 40) begin
			@(negedge clk);
			n++;
		end
		check("forced off cycles", n[7:0], 8'(HOLD), 8'hFF);
		@(posedge clk);
		esd <= 1'b0;
		rdx(OFF_IRQ_STAT, 8'h10, 8'h10);
		wrr(OFF_AUX1_CTL, 8'h3C);
		settle(2);
		check("enable off", {7'h0, en}, 8'h00, 8'hFF);
		check("discharge", {6'h0, dis}, 8'h00, 8'hFF);
		complete_run();
	end
endmodule : power_good_tree_mask_regs_tb
`default_nettype wire
